// >>> core/sysctl_core.sv
// System control registers: sleep, MCU control, clock gating, reset.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////

module sysctl_core import sysctl_pkg::*; #(
   parameter int PINS         = 32,
   parameter int VEC_W        = 16,
   parameter int BOOT_WORDS   = BOOT_MIN_WORDS,
   parameter int TIMEOUT_BASE = TIMEOUT_BASE_CYCLES
) (
   // Clock and board reset
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   // Core register access
   input  wire logic [5:0]       io_addr_i,
   input  wire logic             io_wr_i,
   input  wire logic             io_rd_i,
   input  wire logic [15:0]      ds_addr_i,
   input  wire logic             ds_wr_i,
   input  wire logic             ds_rd_i,
   input  wire logic [7:0]       wdata_i,
   output logic      [7:0]       rdata_o,
   // Core status
   input  wire logic             sleep_instr_i,
   input  wire logic             instr_retire_i,
   input  wire logic             exec_in_boot_i,
   input  wire logic             timer_two_async_select_i,
   // Fuses
   input  wire logic             scan_port_fuse_i,
   input  wire logic             app_side_boot_lock_i,
   input  wire logic             boot_side_boot_lock_i,
   input  wire logic [1:0]       boot_size_fuses_i,
   input  wire logic [1:0]       startup_time_fuses_i,
   // Port pull-up request
   input  wire logic [PINS-1:0]  pin_direction_bit_i,
   input  wire logic [PINS-1:0]  pin_output_bit_i,
   output logic      [PINS-1:0]  pullup_enable_o,
   // Reset sources
   input  wire logic             por_low_i,
   input  wire logic             ext_reset_n_i,
   input  wire logic             bod_low_i,
   input  wire logic             bod_enable_i,
   input  wire logic             scan_reset_i,
   input  wire logic             wdt_expire_i,
   input  wire logic             wdt_reset_mode_i,
   // Control outputs
   output logic                  sleep_enter_o,
   output logic      [2:0]       sleep_mode_o,
   output logic                  scan_port_enable_o,
   output logic      [VEC_W-1:0] vector_base_o,
   output logic                  irq_mask_o,
   output logic      [7:0]       clk_en_o,
   output logic                  cmp_mux_allow_o,
   output logic                  port_reset_o,
   output logic                  sys_rst_n_o
);

   if (PINS < 1 || VEC_W < 8 || BOOT_WORDS < 1 ||
       BOOT_WORDS * 8 > (1 << VEC_W)) begin : g_chk
      $error("sysctl_core parameters out of range");
   end

   //////////////////////////////////////////////////////////////////////////
   // Reset and fuse inputs.

   logic       sys_rst_n;
   logic       fuse_scan;
   logic       fuse_app_lock;
   logic       fuse_boot_lock;
   logic [1:0] fuse_boot_size;

   reset_collector #(
      .TIMEOUT_BASE (TIMEOUT_BASE)
   ) u_reset (
      .clk_i                (clk_i),
      .rst_n_i              (rst_n_i),
      .por_low_i            (por_low_i),
      .ext_reset_n_i        (ext_reset_n_i),
      .bod_low_i            (bod_low_i),
      .bod_enable_i         (bod_enable_i),
      .scan_reset_i         (scan_reset_i),
      .wdt_expire_i         (wdt_expire_i),
      .wdt_reset_mode_i     (wdt_reset_mode_i),
      .startup_time_fuses_i (startup_time_fuses_i),
      .port_reset_o         (port_reset_o),
      .sys_rst_n_o          (sys_rst_n)
   );

   assign sys_rst_n_o = sys_rst_n;

   pin_sync #(
      .W (5)
   ) u_fuse_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i ({scan_port_fuse_i, app_side_boot_lock_i,
                 boot_side_boot_lock_i, boot_size_fuses_i}),
      .sync_o  ({fuse_scan, fuse_app_lock, fuse_boot_lock, fuse_boot_size})
   );

   //////////////////////////////////////////////////////////////////////////
   // Register writes and timed unlock sequences.

   logic [15:0] io_as_data;
   logic [15:0] wr_addr;
   reg_sel_t    wr_sel;
   logic        mcu_wr;
   logic [7:0]  sleep_ctrl_q, sleep_ctrl_d;
   logic [7:0]  gate_q, gate_d;
   logic        spd_q, spd_d;
   logic        spd_pend_q, spd_pend_d;
   logic [2:0]  spd_win_q, spd_win_d;
   logic        pud_q, pud_d;
   logic        vector_table_select_q, vector_table_select_d;
   logic        vector_change_unlock_q, vector_change_unlock_d;
   logic [2:0]  vector_change_unlock_cnt_q, vector_change_unlock_cnt_d;
   logic        post_q, post_d;

   always_comb begin
      io_as_data   = {10'h000, io_addr_i} + IO_DATA_OFFSET;
      // Short I/O addresses never reach the extended region.
      wr_addr      = ds_wr_i ? ds_addr_i : io_as_data;
      wr_sel       = (ds_wr_i | io_wr_i) ? reg_decode(wr_addr) : SEL_NONE;
      mcu_wr       = (wr_sel == SEL_MCU);
      sleep_ctrl_d = sleep_ctrl_q;
      gate_d       = gate_q;
      spd_d        = spd_q;
      spd_pend_d   = spd_pend_q;
      spd_win_d    = spd_win_q;
      pud_d        = pud_q;
      vector_table_select_d      = vector_table_select_q;
      vector_change_unlock_d       = vector_change_unlock_q;
      vector_change_unlock_cnt_d   = vector_change_unlock_cnt_q;
      post_d       = post_q;
      if (spd_win_q != 3'h0) begin
         spd_win_d = spd_win_q - 3'h1;
      end
      if (vector_change_unlock_q) begin
         vector_change_unlock_cnt_d = vector_change_unlock_cnt_q - 3'h1;
         if (vector_change_unlock_cnt_q == 3'h1) begin
            vector_change_unlock_d = 1'b0;
         end
      end
      if (post_q && instr_retire_i) begin
         post_d = 1'b0;
      end
      if (wr_sel == SEL_SLEEP) begin
         sleep_ctrl_d = wdata_i & SLEEP_CONTROL_USED;
      end
      if (wr_sel == SEL_GATE) begin
         gate_d = wdata_i;
      end
      if (mcu_wr) begin
         pud_d = wdata_i[PULLUP_OFF_POS];
         if (wdata_i[SCAN_DISABLE_POS] == spd_q) begin
            spd_win_d = 3'h0;
         end else if (spd_win_q != 3'h0 &&
                      wdata_i[SCAN_DISABLE_POS] == spd_pend_q) begin
            spd_d     = spd_pend_q;
            spd_win_d = 3'h0;
         end else begin
            spd_pend_d = wdata_i[SCAN_DISABLE_POS];
            spd_win_d  = UNLOCK_CYCLES;
         end
         if (wdata_i[VECTOR_UNLOCK_POS]) begin
            vector_change_unlock_d     = 1'b1;
            vector_change_unlock_cnt_d = UNLOCK_CYCLES;
         end else if (vector_change_unlock_q) begin
            vector_table_select_d    = wdata_i[VECTOR_SELECT_POS];
            vector_change_unlock_d     = 1'b0;
            vector_change_unlock_cnt_d = 3'h0;
            post_d     = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         sleep_ctrl_q <= SLEEP_CONTROL_RESET;
         gate_q       <= CLOCK_GATING_RESET;
         spd_q        <= MCU_CONTROL_RESET[SCAN_DISABLE_POS];
         spd_pend_q   <= 1'b0;
         spd_win_q    <= 3'h0;
         pud_q        <= MCU_CONTROL_RESET[PULLUP_OFF_POS];
         vector_table_select_q      <= MCU_CONTROL_RESET[VECTOR_SELECT_POS];
         vector_change_unlock_q       <= MCU_CONTROL_RESET[VECTOR_UNLOCK_POS];
         vector_change_unlock_cnt_q   <= 3'h0;
         post_q       <= 1'b0;
      end else begin
         sleep_ctrl_q <= sleep_ctrl_d;
         gate_q       <= gate_d;
         spd_q        <= spd_d;
         spd_pend_q   <= spd_pend_d;
         spd_win_q    <= spd_win_d;
         pud_q        <= pud_d;
         vector_table_select_q      <= vector_table_select_d;
         vector_change_unlock_q       <= vector_change_unlock_d;
         vector_change_unlock_cnt_q   <= vector_change_unlock_cnt_d;
         post_q       <= post_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Registered control outputs and read data.

   logic [2:0]       mode;
   logic [15:0]      rd_addr;
   logic [7:0]       rdata_q, rdata_d;
   logic             enter_q, enter_d;
   logic [2:0]       mode_q, mode_d;
   logic             scan_en_q, scan_en_d;
   logic [VEC_W-1:0] vec_q, vec_d;
   logic             mask_q, mask_d;
   logic [7:0]       clk_en_q, clk_en_d;
   logic             cmp_q, cmp_d;
   logic [PINS-1:0]  pull_q, pull_d;

   always_comb begin
      mode      = sleep_ctrl_q[SLEEP_MODE_HI_POS:SLEEP_MODE_LO_POS];
      enter_d   = sleep_instr_i & sleep_ctrl_q[SLEEP_ENABLE_POS]
                & (mode != MODE_RESERVED_A) & (mode != MODE_RESERVED_B);
      mode_d    = enter_d ? mode : mode_q;
      scan_en_d = fuse_scan & ~spd_q;
      vec_d     = '0;
      if (vector_table_select_q) begin
         vec_d = VEC_W'((1 << VEC_W) - (BOOT_WORDS << fuse_boot_size));
      end
      mask_d    = vector_change_unlock_d | post_d
                | (vector_table_select_q & fuse_app_lock & ~exec_in_boot_i)
                | (~vector_table_select_q & fuse_boot_lock & exec_in_boot_i);
      // Gating only withholds the enable, so module state is frozen.
      clk_en_d  = ~gate_q;
      clk_en_d[GATE_TIMER_TWO_POS] = ~(gate_q[GATE_TIMER_TWO_POS]
                                     & ~timer_two_async_select_i);
      cmp_d     = ~gate_q[GATE_CONVERTER_POS];
      pull_d    = ~pin_direction_bit_i & pin_output_bit_i
                & {PINS{~pud_q}};
      rd_addr   = ds_rd_i ? ds_addr_i : io_as_data;
      rdata_d   = rdata_q;
      if (ds_rd_i | io_rd_i) begin
         unique case (reg_decode(rd_addr))
            SEL_SLEEP: rdata_d = sleep_ctrl_q;
            SEL_MCU:   rdata_d = {spd_q, 2'b00, pud_q, 2'b00,
                                  vector_table_select_q, vector_change_unlock_q};
            SEL_GATE:  rdata_d = gate_q;
            SEL_NONE:  rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         rdata_q   <= 8'h00;
         enter_q   <= 1'b0;
         mode_q    <= MODE_IDLE;
         scan_en_q <= 1'b0;
         vec_q     <= '0;
         mask_q    <= 1'b0;
         clk_en_q  <= 8'h00;
         cmp_q     <= 1'b0;
         pull_q    <= '0;
      end else begin
         rdata_q   <= rdata_d;
         enter_q   <= enter_d;
         mode_q    <= mode_d;
         scan_en_q <= scan_en_d;
         vec_q     <= vec_d;
         mask_q    <= mask_d;
         clk_en_q  <= clk_en_d;
         cmp_q     <= cmp_d;
         pull_q    <= pull_d;
      end
   end

   assign rdata_o            = rdata_q;
   assign sleep_enter_o      = enter_q;
   assign sleep_mode_o       = mode_q;
   assign scan_port_enable_o = scan_en_q;
   assign vector_base_o      = vec_q;
   assign irq_mask_o         = mask_q;
   assign clk_en_o           = clk_en_q;
   assign cmp_mux_allow_o    = cmp_q;
   assign pullup_enable_o    = pull_q;

   //////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!sys_rst_n);

   sequence s_vector_change_unlock_set;
      mcu_wr && wdata_i[VECTOR_UNLOCK_POS];
   endsequence

   sequence s_quiet4;
      (!mcu_wr)[*4];
   endsequence

   sequence s_spd_first;
      mcu_wr && (wdata_i[SCAN_DISABLE_POS] != spd_q) && spd_win_q == 3'h0;
   endsequence

   AST_SLEEP_NEEDS_ENABLE: assert property (
      sleep_instr_i && !sleep_ctrl_q[SLEEP_ENABLE_POS] |=> !sleep_enter_o)
      else $error("sleep entered with sleep enable clear");

   AST_SLEEP_RESERVED: assert property (
      sleep_instr_i && (mode == MODE_RESERVED_A || mode == MODE_RESERVED_B)
      |=> !sleep_enter_o)
      else $error("sleep entered with a reserved mode");

   AST_SPD_SINGLE_WRITE: assert property (
      s_spd_first |=> $stable(spd_q))
      else $error("scan disable changed on a single write");

   AST_SPD_DOUBLE_WRITE: assert property (
      s_spd_first ##1 !mcu_wr ##1
      (mcu_wr && wdata_i[SCAN_DISABLE_POS] == spd_pend_q)
      |=> spd_q == spd_pend_q)
      else $error("scan disable ignored a second write in time");

   AST_SCAN_PORT: assert property (
      $past(sys_rst_n) |-> scan_port_enable_o == $past(fuse_scan && !spd_q))
      else $error("scan port enable does not follow fuse and bit");

   AST_PULLUP_OFF: assert property (
      pud_q |=> pullup_enable_o == '0)
      else $error("pull-up enabled while globally off");

   AST_VECTOR_CHANGE_UNLOCK_MASK: assert property (
      s_vector_change_unlock_set |=> vector_change_unlock_q && irq_mask_o)
      else $error("unlock did not mask interrupts at once");

   AST_VECTOR_CHANGE_UNLOCK_TIMEOUT: assert property (
      s_vector_change_unlock_set ##1 s_quiet4 |=> !vector_change_unlock_q)
      else $error("unlock bit held longer than four cycles");

   AST_VECTOR_TABLE_SELECT_LOCKED: assert property (
      !vector_change_unlock_q |=> $stable(vector_table_select_q))
      else $error("vector select changed without unlock");

   AST_VECTOR_TABLE_SELECT_WRITE: assert property (
      mcu_wr && vector_change_unlock_q && !wdata_i[VECTOR_UNLOCK_POS]
      |=> vector_table_select_q == $past(wdata_i[VECTOR_SELECT_POS]) && !vector_change_unlock_q
          && irq_mask_o)
      else $error("unlocked vector select write not taken");

   AST_TIMER_TWO_GATE: assert property (
      sys_rst_n && timer_two_async_select_i
      |=> clk_en_o[GATE_TIMER_TWO_POS])
      else $error("asynchronous timer two was gated");

   AST_CMP_MUX: assert property (
      gate_q[GATE_CONVERTER_POS] |=> !cmp_mux_allow_o)
      else $error("comparator mux allowed while converter gated");

endmodule

// >>> core/sysctl_pkg.sv
// Shared constants and types of the system control and reset block.
package sysctl_pkg;

   // Data-space addresses of the registers.
   localparam logic [15:0] SLEEP_CONTROL_ADDR = 16'h0053;
   localparam logic [15:0] MCU_CONTROL_ADDR   = 16'h0055;
   localparam logic [15:0] CLOCK_GATING_ADDR  = 16'h0064;
   localparam logic [15:0] IO_DATA_OFFSET     = 16'h0020;
   localparam logic [15:0] EXT_IO_BASE        = 16'h0060;

   // Reset values and implemented bits.
   localparam logic [7:0] SLEEP_CONTROL_RESET = 8'h00;
   localparam logic [7:0] MCU_CONTROL_RESET   = 8'h00;
   localparam logic [7:0] CLOCK_GATING_RESET  = 8'h00;
   localparam logic [7:0] SLEEP_CONTROL_USED  = 8'h0f;

   // Field positions.
   localparam int SLEEP_ENABLE_POS      = 0;
   localparam int SLEEP_MODE_LO_POS     = 1;
   localparam int SLEEP_MODE_HI_POS     = 3;
   localparam int SCAN_DISABLE_POS      = 7;
   localparam int PULLUP_OFF_POS        = 4;
   localparam int VECTOR_SELECT_POS     = 1;
   localparam int VECTOR_UNLOCK_POS     = 0;
   localparam int GATE_TWO_WIRE_POS     = 7;
   localparam int GATE_TIMER_TWO_POS    = 6;
   localparam int GATE_TIMER_ZERO_POS   = 5;
   localparam int GATE_SERIAL_ONE_POS   = 4;
   localparam int GATE_TIMER_ONE_POS    = 3;
   localparam int GATE_SPI_POS          = 2;
   localparam int GATE_SERIAL_ZERO_POS  = 1;
   localparam int GATE_CONVERTER_POS    = 0;

   // Sleep mode encodings.
   localparam logic [2:0] MODE_IDLE        = 3'h0;
   localparam logic [2:0] MODE_NOISE_RED   = 3'h1;
   localparam logic [2:0] MODE_POWER_DOWN  = 3'h2;
   localparam logic [2:0] MODE_POWER_SAVE  = 3'h3;
   localparam logic [2:0] MODE_RESERVED_A  = 3'h4;
   localparam logic [2:0] MODE_RESERVED_B  = 3'h5;
   localparam logic [2:0] MODE_STANDBY     = 3'h6;
   localparam logic [2:0] MODE_EXT_STANDBY = 3'h7;

   // Timing counts in system clock cycles; the smallest boot section in words.
   localparam logic [2:0] UNLOCK_CYCLES       = 3'h4;
   localparam int         TIMEOUT_BASE_CYCLES = 16;
   localparam int         BOOT_MIN_WORDS      = 256;

   typedef enum logic [1:0] {
      SEL_NONE,
      SEL_SLEEP,
      SEL_MCU,
      SEL_GATE
   } reg_sel_t;

   function automatic reg_sel_t reg_decode(input logic [15:0] addr);
      reg_sel_t sel;
      sel = SEL_NONE;
      if (addr == SLEEP_CONTROL_ADDR) sel = SEL_SLEEP;
      if (addr == MCU_CONTROL_ADDR) sel = SEL_MCU;
      if (addr == CLOCK_GATING_ADDR) sel = SEL_GATE;
      return sel;
   endfunction

endpackage

// >>> core/pin_sync.sv
// Two-flop synchroniser for levels arriving from pins and fuses.
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   // Data
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   if (W < 1) begin : g_chk
      $error("pin_sync width must be at least one");
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule

// >>> core/reset_collector.sv
// Reset source collector with the stretching delay counter.
`timescale 1ns/1ps
module reset_collector import sysctl_pkg::*; #(
   parameter int TIMEOUT_BASE = TIMEOUT_BASE_CYCLES
) (
   // Clock and board reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Reset sources
   input  wire logic       por_low_i,
   input  wire logic       ext_reset_n_i,
   input  wire logic       bod_low_i,
   input  wire logic       bod_enable_i,
   input  wire logic       scan_reset_i,
   input  wire logic       wdt_expire_i,
   input  wire logic       wdt_reset_mode_i,
   input  wire logic [1:0] startup_time_fuses_i,
   // Reset outputs
   output logic            port_reset_o,
   output logic            sys_rst_n_o
);

   localparam int CW = $clog2(TIMEOUT_BASE * 8 + 1);

   logic          src_rst_n;
   logic          hold_q, hold_d;
   logic          rst_n_q;
   logic          loaded_q, loaded_d;
   logic          wdt_q, wdt_d;
   logic [CW-1:0] cnt_q, cnt_d;

   if (TIMEOUT_BASE < 1) begin : g_chk
      $error("reset time-out base must be at least one cycle");
   end

   // Any asynchronous source forces reset at once, clock or not.
   assign src_rst_n = rst_n_i & ~por_low_i & ext_reset_n_i
                    & ~(bod_low_i & bod_enable_i)
                    & ~scan_reset_i;

   always_comb begin
      wdt_d    = wdt_expire_i & wdt_reset_mode_i & ~wdt_q;
      hold_d   = hold_q;
      loaded_d = loaded_q;
      cnt_d    = cnt_q;
      if (wdt_q) begin
         hold_d   = 1'b1;
         loaded_d = 1'b0;
      end else if (!loaded_q) begin
         cnt_d    = CW'(TIMEOUT_BASE) << startup_time_fuses_i;
         loaded_d = 1'b1;
      end else if (hold_q) begin
         cnt_d = cnt_q - CW'(1);
         if (cnt_q == CW'(1)) begin
            hold_d = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge src_rst_n) begin
      if (!src_rst_n) begin
         hold_q   <= 1'b1;
         rst_n_q  <= 1'b0;
         loaded_q <= 1'b0;
         wdt_q    <= 1'b0;
         cnt_q    <= '0;
      end else begin
         hold_q   <= hold_d;
         rst_n_q  <= ~hold_d;
         loaded_q <= loaded_d;
         wdt_q    <= wdt_d;
         cnt_q    <= cnt_d;
      end
   end

   assign port_reset_o = hold_q;
   assign sys_rst_n_o  = rst_n_q;

   AST_WDT_ONE_CYCLE: assert property (@(posedge clk_i)
      disable iff (!src_rst_n) wdt_q |=> !wdt_q && hold_q)
      else $error("watchdog reset pulse longer than one cycle");

   AST_STRETCH: assert property (@(posedge clk_i)
      disable iff (!src_rst_n) (hold_q && !loaded_q && !wdt_q) |=> hold_q)
      else $error("internal reset released before the delay count");

endmodule

// >>> dv/core_bus_model.sv
// Behavioural processor core issuing short I/O and data-space accesses.
`timescale 1ns/1ps
module core_bus_model (
   // Clock
   input  wire logic        clk_i,
   // Register access
   output logic      [5:0]  io_addr_o,
   output logic             io_wr_o,
   output logic             io_rd_o,
   output logic      [15:0] ds_addr_o,
   output logic             ds_wr_o,
   output logic             ds_rd_o,
   output logic      [7:0]  wdata_o,
   input  wire logic [7:0]  rdata_i
);
   initial begin
      {io_wr_o, io_rd_o, ds_wr_o, ds_rd_o} = '0;
      {io_addr_o, ds_addr_o, wdata_o} = '0;
   end
   // One access, short I/O form when io is set; read data returns in q.
   task automatic access(input logic io, input logic wr,
                         input logic [15:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      @(posedge clk_i);
      #1;
      io_addr_o = a[5:0];
      ds_addr_o = a;
      wdata_o = d;
      {io_wr_o, io_rd_o} = {io & wr, io & ~wr};
      {ds_wr_o, ds_rd_o} = {~io & wr, ~io & ~wr};
      @(posedge clk_i);
      #1;
      {io_wr_o, io_rd_o, ds_wr_o, ds_rd_o} = '0;
      // Released lines show the inverse rather than the stale value.
      io_addr_o = ~a[5:0];
      ds_addr_o = ~a;
      wdata_o = ~d;
      q = rdata_i;
   endtask
endmodule

// >>> dv/test_system_control_power_reset.sv
// Self-checking bench for the system control and reset block.
`timescale 1ns/1ps
`define CHK(g, e) begin \
   n_compared++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("[ERR] %0t got %h want %h", $time, g, e); \
   end \
end
module test_system_control_power_reset import sysctl_pkg::*;;
   logic clk_i = 0, rst_n_i = 0, sleep_instr_i = 0, instr_retire_i = 0;
   logic exec_in_boot_i = 0, timer_two_async_select_i = 0;
   logic app_side_boot_lock_i = 0, por_low_i = 0, ext_reset_n_i = 1;
   logic bod_low_i = 0, bod_enable_i = 0, scan_reset_i = 0;
   logic wdt_expire_i = 0, wdt_reset_mode_i = 0;
   logic [31:0] pin_output_bit_i = '1;
   logic [31:0] pin_direction_bit_i = '0;
   logic        boot_side_boot_lock_i = 0;
   logic [7:0]  q;
   int          n_errors = 0, n_compared = 0, n;
   wire logic [5:0]  io_addr_i;
   wire logic [15:0] ds_addr_i, vector_base_o;
   wire logic [7:0]  wdata_i, rdata_o, clk_en_o;
   wire logic [31:0] pullup_enable_o;
   wire logic [2:0]  sleep_mode_o;
   wire logic io_wr_i, io_rd_i, ds_wr_i, ds_rd_i, sleep_enter_o, irq_mask_o;
   wire logic scan_port_enable_o, cmp_mux_allow_o, port_reset_o, sys_rst_n_o;
   sysctl_core #(.TIMEOUT_BASE(2)) uut (.*, .scan_port_fuse_i(1'b1),
      .boot_size_fuses_i(2'h0), .startup_time_fuses_i(2'h0));
   core_bus_model bus (.clk_i, .io_addr_o(io_addr_i), .io_wr_o(io_wr_i),
      .io_rd_o(io_rd_i), .ds_addr_o(ds_addr_i), .ds_wr_o(ds_wr_i),
      .ds_rd_o(ds_rd_i), .wdata_o(wdata_i), .rdata_i(rdata_o));
   initial forever #5 clk_i = ~clk_i;
   initial begin
      #300000;
      n_errors++;
      give_verdict();
   end
   //////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic io, input logic [15:0] a, input logic [7:0] d);
      bus.access(io, 1'b1, a, d, q);
   endtask
   task automatic wait_up();
      n = 0;
      while (sys_rst_n_o !== 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic t_regs();
      logic [15:0] a [4];
      a = '{16'h0053, 16'h0055, 16'h0064, 16'h0065};
      for (int i = 0; i < 4; i++) begin
         bus.access(1'b0, 1'b0, a[i], 8'h00, q);
         `CHK(q, 8'h00)
      end
      `CHK(clk_en_o, 8'hff)
   endtask
   task automatic t_gate();
      wr(1'b0, 16'h64, 8'h41);
      cyc(2);
      `CHK(clk_en_o, 8'hbe)
      `CHK(cmp_mux_allow_o, 1'b0)
      timer_two_async_select_i = 1;
      cyc(2);
      `CHK(clk_en_o, 8'hfe)
      bus.access(1'b0, 1'b0, 16'h64, 8'h00, q);
      `CHK(q, 8'h41)
   endtask
   task automatic t_mcu();
      `CHK(pullup_enable_o, 32'hffffffff)
      pin_direction_bit_i = 32'h0000ffff;
      cyc(1);
      `CHK(pullup_enable_o, 32'hffff0000)
      wr(1'b1, 16'h35, 8'h90);
      cyc(5);
      `CHK(pullup_enable_o, 32'h0)
      `CHK(scan_port_enable_o, 1'b1)
      wr(1'b1, 16'h35, 8'h90);
      wr(1'b1, 16'h35, 8'h90);
      cyc(2);
      `CHK(scan_port_enable_o, 1'b0)
   endtask
   task automatic t_vec();
      wr(1'b1, 16'h35, 8'h91);
      cyc(1);
      `CHK(irq_mask_o, 1'b1)
      wr(1'b1, 16'h35, 8'h92);
      cyc(2);
      `CHK(vector_base_o, 16'hff00)
      `CHK(irq_mask_o, 1'b1)
      instr_retire_i = 1;
      cyc(1);
      instr_retire_i = 0;
      cyc(2);
      `CHK(irq_mask_o, 1'b0)
      wr(1'b1, 16'h35, 8'h93);
      cyc(6);
      bus.access(1'b0, 1'b0, 16'h55, 8'h00, q);
      `CHK(q, 8'h92)
      app_side_boot_lock_i = 1;
      cyc(5);
      `CHK(irq_mask_o, 1'b1)
      exec_in_boot_i = 1;
      boot_side_boot_lock_i = 1;
      cyc(4);
      `CHK(irq_mask_o, 1'b0)
   endtask
   task automatic t_sleep();
      logic [2:0] m, last;
      last = 3'h0;
      for (int i = 0; i < 9; i++) begin
         m = i[2:0];
         wr(1'b1, 16'h33, {4'h0, m, i < 8});
         sleep_instr_i = 1;
         cyc(1);
         sleep_instr_i = 0;
         if (i < 8 && m[2:1] != 2'b10) last = m;
         `CHK(sleep_enter_o, i < 8 && m[2:1] != 2'b10)
         `CHK(sleep_mode_o, last)
      end
   endtask
   task automatic rst_src(input logic [3:0] s);
      wr(1'b0, 16'h64, 8'h3c);
      cyc(1);
      {bod_low_i, bod_enable_i, scan_reset_i} = {s[3], s[3], s[2]};
      {ext_reset_n_i, por_low_i} = {~s[1], s[0]};
      #1;
      `CHK(port_reset_o, 1'b1)
      `CHK(sys_rst_n_o, 1'b0)
      cyc(1);
      {bod_low_i, bod_enable_i, scan_reset_i, ext_reset_n_i, por_low_i} = 5'h2;
      wait_up();
      `CHK(n, 3)
      bus.access(1'b0, 1'b0, 16'h64, 8'h00, q);
      `CHK(q, 8'h00)
   endtask
   task automatic t_wdog();
      for (int k = 0; k < 2; k++) begin
         wdt_reset_mode_i = k[0];
         wdt_expire_i = 1;
         cyc(1);
         wdt_expire_i = 0;
         cyc(2);
         `CHK(sys_rst_n_o, !k[0])
      end
      // The load edge after the pulse fell has passed; two edges remain.
      wait_up();
      `CHK(n, 2)
   endtask
   task automatic give_verdict();
      if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      cyc(12);
      rst_n_i = 1;
      wait_up();
      t_regs();
      t_gate();
      t_mcu();
      t_vec();
      t_sleep();
      for (int k = 0; k < 4; k++) rst_src(4'h1 << k);
      // Vectors are back in the application while boot code runs.
      `CHK(irq_mask_o, 1'b1)
      t_wdog();
      give_verdict();
   end
endmodule
